// ==== logic/ppi_instance.v ====
`include "ppi_regs.vh"
`default_nettype none
module ppi_instance (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       wr_en,
  input  wire [1:0] reg_sel,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  input  wire [7:0] port_a_in,
  output wire [7:0] port_a_out,
  output wire [7:0] port_a_oe,
  input  wire [7:0] port_b_in,
  output wire [7:0] port_b_out,
  output wire [7:0] port_b_oe,
  input  wire [7:0] port_c_in,
  output wire [7:0] port_c_out,
  output wire [7:0] port_c_oe
);
  reg  [6:0] ctl_q;
  reg  [6:0] ctl_d;
  reg  [7:0] lat_a_q;
  reg  [7:0] lat_b_q;
  reg  [7:0] lat_c_q;
  reg  [7:0] lat_a_d;
  reg  [7:0] lat_b_d;
  reg  [7:0] lat_c_d;
  wire [7:0] dir_c;
  wire [2:0] ofs;
  wire       mode_chg;
  wire [2:0] port_c_bit_select;
  wire       port_a_direction;
  wire       port_b_direction;
  wire       port_c_high_direction;
  wire       port_c_low_direction;
  genvar     gi;

  function [7:0] mix;
    input [7:0] pins;
    input [7:0] latch;
    input [7:0] is_in;
    begin
      mix = (pins & is_in) | (latch & ~is_in);
    end
  endfunction

  assign port_a_direction      = ctl_q[`PPI_CTL_ADIR_BIT];  // RULE8
  assign port_b_direction      = ctl_q[`PPI_CTL_BDIR_BIT];  // RULE6
  assign port_c_high_direction = ctl_q[`PPI_CTL_CHDIR_BIT]; // RULE7
  assign port_c_low_direction  = ctl_q[`PPI_CTL_CLDIR_BIT]; // RULE5
  assign dir_c = {{4{port_c_high_direction}}, {4{port_c_low_direction}}};
  assign ofs   = {1'b0, reg_sel}; // RULE1
  assign port_c_bit_select  = wr_data[`PPI_PORT_C_BIT_SELECT_HI:`PPI_PORT_C_BIT_SELECT_LO]; // RULE15
  // RULE9 RULE10 RULE11
  assign mode_chg =
    (wr_data[`PPI_CTL_MODEA_HI:`PPI_CTL_MODEA_LO] !=
     ctl_q[`PPI_CTL_MODEA_HI:`PPI_CTL_MODEA_LO]) ||
    (wr_data[`PPI_CTL_MODEB_BIT] != ctl_q[`PPI_CTL_MODEB_BIT]);

  // Outputs: direction 1 releases the line; reset releases it at once
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      assign port_a_oe[gi]  = ~reset & ~port_a_direction;    // RULE2 RULE16
      assign port_b_oe[gi]  = ~reset & ~port_b_direction;    // RULE2 RULE16
      assign port_c_oe[gi]  = ~reset & ~dir_c[gi];           // RULE2 RULE16
      assign port_a_out[gi] = reset | lat_a_q[gi];           // RULE2
      assign port_b_out[gi] = reset | lat_b_q[gi];           // RULE2
      assign port_c_out[gi] = reset | lat_c_q[gi];           // RULE2
    end
  endgenerate

  always @* begin
    ctl_d   = ctl_q;
    lat_a_d = lat_a_q;
    lat_b_d = lat_b_q;
    lat_c_d = lat_c_q;
    if (wr_en) begin
      case (ofs)
        `PPI_OFS_PORT_A: lat_a_d = wr_data; // RULE16
        `PPI_OFS_PORT_B: lat_b_d = wr_data; // RULE16
        `PPI_OFS_PORT_C: lat_c_d = wr_data; // RULE16
        default: begin
          if (wr_data[`PPI_CTL_FLAG_BIT]) begin // RULE4
            ctl_d = wr_data[6:0]; // RULE3
            if (mode_chg) begin // RULE11
              lat_a_d = `PPI_LATCH_RESET;
              lat_b_d = `PPI_LATCH_RESET;
              lat_c_d = `PPI_LATCH_RESET;
            end
          end else begin
            lat_c_d[port_c_bit_select] = wr_data[`PPI_SET_BIT]; // RULE12
          end
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      ctl_q   <= `PPI_CTL_RESET; // RULE2 RULE14
      lat_a_q <= `PPI_LATCH_RESET;
      lat_b_q <= `PPI_LATCH_RESET;
      lat_c_q <= `PPI_LATCH_RESET;
    end else begin
      ctl_q   <= ctl_d;
      lat_a_q <= lat_a_d;
      lat_b_q <= lat_b_d;
      lat_c_q <= lat_c_d;
    end
  end

  always @* begin
    case (ofs)
      `PPI_OFS_PORT_A:
        rd_data = mix(port_a_in, lat_a_q, {8{port_a_direction}});
      `PPI_OFS_PORT_B:
        rd_data = mix(port_b_in, lat_b_q, {8{port_b_direction}});
      `PPI_OFS_PORT_C: rd_data = mix(port_c_in, lat_c_q, dir_c); // RULE16
      default: rd_data = {1'b1, ctl_q}; // RULE13
    endcase
  end
endmodule // ppi_instance
`default_nettype wire

// ==== logic/ppi_regs.vh ====
// Notes on behaviour
// RULE1: Port data at offsets 0-2 and 4-6
// RULE2: Reset: all lines input, pulled high
// RULE3: Ports stay input until control write
// RULE4: Control at 3 and 7, flag-high write
// RULE5: Port C low direction, 0 output
// RULE6: Port B direction, 0 output
// RULE7: Port C high direction, 0 output
// RULE8: Port A direction, 0 output
// RULE9: Group B mode bit, reset zero
// RULE10: Group A two-bit mode, reset zero
// RULE11: Mode change clears output latches
// RULE12: Flag-low write sets/clears one C bit
// RULE13: Control read shows flag as one
// RULE14: Stored flag reads one after reset
// RULE15: Bit select bits 3:1, value bit 0
// RULE16: Read pins for inputs, latch for outputs
`ifndef PPI_REGS_VH
`define PPI_REGS_VH
`define PPI_OFS_PORT_A      3'h0
`define PPI_OFS_PORT_B      3'h1
`define PPI_OFS_PORT_C      3'h2
`define PPI_OFS_CONTROL     3'h3
`define PPI_CTL_FLAG_BIT    7
`define PPI_CTL_MODEA_HI    6
`define PPI_CTL_MODEA_LO    5
`define PPI_CTL_ADIR_BIT    4
`define PPI_CTL_CHDIR_BIT   3
`define PPI_CTL_MODEB_BIT   2
`define PPI_CTL_BDIR_BIT    1
`define PPI_CTL_CLDIR_BIT   0
`define PPI_PORT_C_BIT_SELECT_HI         3
`define PPI_PORT_C_BIT_SELECT_LO         1
`define PPI_SET_BIT         0
`define PPI_CTL_RESET       7'h1b
`define PPI_LATCH_RESET     8'h00
`endif

// ==== logic/dual_ppi_parallel_port.v ====
`include "ppi_regs.vh"
`default_nettype none
module dual_ppi_parallel_port (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [4:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  p1_port_a_in,
  output wire [7:0]  p1_port_a_out,
  output wire [7:0]  p1_port_a_oe,
  input  wire [7:0]  p1_port_b_in,
  output wire [7:0]  p1_port_b_out,
  output wire [7:0]  p1_port_b_oe,
  input  wire [7:0]  p1_port_c_in,
  output wire [7:0]  p1_port_c_out,
  output wire [7:0]  p1_port_c_oe,
  input  wire [7:0]  p2_port_a_in,
  output wire [7:0]  p2_port_a_out,
  output wire [7:0]  p2_port_a_oe,
  input  wire [7:0]  p2_port_b_in,
  output wire [7:0]  p2_port_b_out,
  output wire [7:0]  p2_port_b_oe,
  input  wire [7:0]  p2_port_c_in,
  output wire [7:0]  p2_port_c_out,
  output wire [7:0]  p2_port_c_oe
);
  wire       req;
  wire [2:0] idx;
  wire       wr1;
  wire       wr2;
  wire [7:0] rd1;
  wire [7:0] rd2;

  // Byte address is index times four; byte lane 0 carries data
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = wb_adr_i[4:2];
  assign wr1 = req & wb_we_i & wb_sel_i[0] & ~idx[2]; // RULE1 RULE4
  assign wr2 = req & wb_we_i & wb_sel_i[0] & idx[2];  // RULE1 RULE4

  ppi_instance u_ppi1 (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr_en      (wr1),
    .reg_sel    (idx[1:0]),
    .wr_data    (wb_dat_i[7:0]),
    .rd_data    (rd1),
    .port_a_in  (p1_port_a_in),
    .port_a_out (p1_port_a_out),
    .port_a_oe  (p1_port_a_oe),
    .port_b_in  (p1_port_b_in),
    .port_b_out (p1_port_b_out),
    .port_b_oe  (p1_port_b_oe),
    .port_c_in  (p1_port_c_in),
    .port_c_out (p1_port_c_out),
    .port_c_oe  (p1_port_c_oe)
  );

  ppi_instance u_ppi2 (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr_en      (wr2),
    .reg_sel    (idx[1:0]),
    .wr_data    (wb_dat_i[7:0]),
    .rd_data    (rd2),
    .port_a_in  (p2_port_a_in),
    .port_a_out (p2_port_a_out),
    .port_a_oe  (p2_port_a_oe),
    .port_b_in  (p2_port_b_in),
    .port_b_out (p2_port_b_out),
    .port_b_oe  (p2_port_b_oe),
    .port_c_in  (p2_port_c_in),
    .port_c_out (p2_port_c_out),
    .port_c_oe  (p2_port_c_oe)
  );

  always @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= {24'h000000, idx[2] ? rd2 : rd1}; // RULE1
    end
  end
endmodule // dual_ppi_parallel_port
`default_nettype wire

// ==== tb/io_pins.sv ====
`default_nettype none
module io_pins (
  input  wire logic [7:0] o,
  input  wire logic [7:0] e,
  input  wire logic [7:0] x,
  output logic      [7:0] p
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven lines read back their own level, released lines the pull level
  assign p = (o & e) | (x & ~e);
endmodule // io_pins
`default_nettype wire

// ==== tb/dual_ppi_parallel_port_checker.sv ====
`default_nettype none
module dual_ppi_parallel_port_checker (
  input wire logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [7:0]  p1_port_a_out, p1_port_a_oe, p1_port_b_oe,
  input wire logic [7:0]  p1_port_c_out, p1_port_c_oe, p2_port_a_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic tk = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  sequence ctl1;
    tk && wb_adr_i == 5'h0c && wb_dat_i[7];
  endsequence
  AST_RESET_HIGH: assert property (disable iff (1'b0)
    reset |-> p1_port_a_out == 8'hff && p1_port_a_oe == 8'h00)
    else $error("port not input high in reset");
  AST_ACK_PULSE: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one cycle answer");
  AST_OE_BY_CTL: assert property (
    $changed(p1_port_a_oe) |-> $past(tk && wb_adr_i == 5'h0c))
    else $error("direction changed without control write");
  AST_DIR: assert property (ctl1 |=>
    p1_port_a_oe == {8{~$past(wb_dat_i[4])}} &&
    p1_port_b_oe == {8{~$past(wb_dat_i[1])}} &&
    p1_port_c_oe == {{4{~$past(wb_dat_i[3])}}, {4{~$past(wb_dat_i[0])}}})
    else $error("direction fields wrong");
  AST_P2_CTL: assert property (
    tk && wb_adr_i == 5'h1c && wb_dat_i[7] |=>
    p2_port_a_oe == {8{~$past(wb_dat_i[4])}})
    else $error("second control word wrong");
  AST_LATCH: assert property (
    tk && wb_adr_i == 5'h00 |=> p1_port_a_out == $past(wb_dat_i[7:0]))
    else $error("data write not latched");
  AST_BITSET: assert property (
    tk && wb_adr_i == 5'h0c && !wb_dat_i[7] |=> $stable(p1_port_c_oe) &&
    p1_port_c_out[$past(wb_dat_i[3:1])] == $past(wb_dat_i[0]))
    else $error("bit set or clear wrong");
  AST_FLAG_READ: assert property (
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 5'h0c
    |=> wb_dat_o[7])
    else $error("control read flag low");
endmodule // dual_ppi_parallel_port_checker
bind dual_ppi_parallel_port dual_ppi_parallel_port_checker u_chk (.*);
`default_nettype wire

// ==== tb/tb_dual_ppi_parallel_port.sv ====
`default_nettype none
module tb_dual_ppi_parallel_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, req = 0, we = 0, wb_ack_o;
  logic [4:0] adr = 0;
  logic [7:0] wd = 0, rd, ext = 8'hff;
  logic [31:0] wb_dat_o;
  logic [7:0] p1_port_a_in, p1_port_a_out, p1_port_a_oe, p1_port_b_in,
    p1_port_b_out, p1_port_b_oe, p1_port_c_in, p1_port_c_out, p1_port_c_oe,
    p2_port_a_in, p2_port_a_out, p2_port_a_oe, p2_port_b_in, p2_port_b_out,
    p2_port_b_oe, p2_port_c_in, p2_port_c_out, p2_port_c_oe;
  int mismatches = 0, check_count = 0;
  always #10 clk_sys = ~clk_sys;
  dual_ppi_parallel_port DUT (.*, .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wd}));
  io_pins m1a(.o(p1_port_a_out), .e(p1_port_a_oe), .x(ext), .p(p1_port_a_in));
  io_pins m1b(.o(p1_port_b_out), .e(p1_port_b_oe), .x(ext), .p(p1_port_b_in));
  io_pins m1c(.o(p1_port_c_out), .e(p1_port_c_oe), .x(ext), .p(p1_port_c_in));
  io_pins m2a(.o(p2_port_a_out), .e(p2_port_a_oe), .x(ext), .p(p2_port_a_in));
  io_pins m2b(.o(p2_port_b_out), .e(p2_port_b_oe), .x(ext), .p(p2_port_b_in));
  io_pins m2c(.o(p2_port_c_out), .e(p2_port_c_oe), .x(ext), .p(p2_port_c_in));
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(n[7:0], 8'h02);
    rd = wb_dat_o[7:0];
    req <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_reset;
    chk(p1_port_a_out & p2_port_c_out, 8'hff);
    chk(p1_port_a_oe | p2_port_b_oe, 8'h00);
    reset <= 1'b0;
    @(posedge clk_sys);
    ext <= 8'h5a;
    bus(0, 5'h0c, 0);
    chk(rd, 8'h9b);
    bus(0, 5'h1c, 0);
    chk(rd, 8'h9b);
    bus(0, 5'h14, 0);
    chk(rd, 8'h5a);
    $display("Test reset done");
  endtask
  task automatic t_dir;
    logic [7:0] c;
    for (int i = 0; i < 32; i++) begin
      c = {3'b100, i[3:2], 1'b0, i[1:0]};
      bus(1, {i[4], 4'hc}, c);
      bus(0, {i[4], 4'hc}, 0);
      chk(rd, c);
      chk(i[4] ? p2_port_b_oe : p1_port_b_oe, {8{~c[1]}});
      chk(i[4] ? p2_port_c_oe : p1_port_c_oe, {{4{~c[3]}}, {4{~c[0]}}});
    end
    $display("Test direction done");
  endtask
  task automatic t_bsr;
    logic [7:0] e;
    e = 8'h00;
    bus(1, 5'h0c, 8'h80);
    bus(1, 5'h08, 8'h00);
    for (int b = 0; b < 16; b++) begin
      bus(1, 5'h0c, {4'h0, b[2:0], ~b[3] | b[0]});
      e[b[2:0]] = ~b[3] | b[0];
      chk(p1_port_c_out, e);
    end
    bus(0, 5'h0c, 0);
    chk(rd, 8'h80);
    bus(0, 5'h08, 0);
    chk(rd, 8'haa);
    $display("Test bit set done");
  endtask
  task automatic t_mode;
    logic [7:0] m [3];
    m = '{8'ha0, 8'hc4, 8'h80};
    bus(1, 5'h1c, 8'h80);
    bus(1, 5'h10, 8'h11);
    bus(1, 5'h14, 8'h22);
    bus(1, 5'h18, 8'h33);
    chk(p2_port_a_out, 8'h11);
    chk({p2_port_b_out[3:0], p2_port_c_out[3:0]}, 8'h23);
    chk(p1_port_c_out, 8'haa);
    foreach (m[k]) begin
      bus(1, 5'h10, 8'hff);
      bus(1, 5'h1c, m[k]);
      chk(p2_port_a_out, 8'h00);
      bus(0, 5'h1c, 0);
      chk(rd, m[k]);
    end
    $display("Test mode done");
  endtask
  task automatic t_rerun;
    reset <= 1'b1;
    @(posedge clk_sys);
    chk(p2_port_a_oe | p1_port_c_oe, 8'h00);
    chk(p2_port_b_out & p1_port_c_out, 8'hff);
    reset <= 1'b0;
    @(posedge clk_sys);
    bus(0, 5'h1c, 0);
    chk(rd, 8'h9b);
    bus(0, 5'h08, 0);
    chk(rd, 8'h5a);
    chk(p2_port_a_out, 8'h00);
    $display("Test reset again done");
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    t_reset;
    t_dir;
    t_bsr;
    t_mode;
    t_rerun;
    close_out;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    close_out;
  end
endmodule // tb_dual_ppi_parallel_port
`default_nettype wire
